// ===== rtl/supply_supervisor_logic.v
// Digital core of a multi-input supply supervisor
`include "supply_supervisor_map.vh"
module supply_supervisor_logic #(
  parameter [31:0] RESET_HOLD_CYCLES = `RESET_HOLD_CYC,
  parameter [31:0] OV_HOLD_CYCLES    = `OV_HOLD_CYC,
  parameter [35:0] WD_INIT_CYCLES    = `WD_INIT_CYC,
  parameter [35:0] WD_NORM_CYCLES    = `WD_NORM_CYC
) (
  input  wire                    clock,
  input  wire                    reset,
  input  wire                    clock_enable,
  input  wire [`NUM_INPUTS-1:0]  undervoltage,
  input  wire [`NUM_INPUTS-1:0]  overvoltage,
  input  wire                    manual_reset_in_n,
  input  wire                    hold_in_n,
  input  wire                    watchdog_kick,
  output reg                     reset_out_n,
  output reg                     reset_out_oe,
  output reg                     overvoltage_out_n,
  output reg                     overvoltage_out_oe,
  output reg                     watchdog_fault_n,
  output reg                     watchdog_fault_oe
);
  localparam [7:0] MR_FILTER = `MR_FILTER_CYC;

  // OR of the per-input comparator flags
  function flag_any;
    input [`NUM_INPUTS-1:0] flags;
    begin
      flag_any = |flags;
    end
  endfunction

  wire mr_n_s;
  wire hold_n_s;
  wire kick_s;
  wire uv_s_any;
  wire ov_s_any;
  wire reset_stretched;
  wire ov_stretched;
  reg  [`NUM_INPUTS-1:0] uv_meta_q;
  reg  [`NUM_INPUTS-1:0] uv_q;
  reg  [`NUM_INPUTS-1:0] ov_meta_q;
  reg  [`NUM_INPUTS-1:0] ov_q;
  reg  [7:0]  mr_low_cnt_q;
  reg         mr_valid_q;
  reg         kick_prev_q;
  reg  [35:0] wd_cnt_q;
  reg         wd_initial_q;
  reg         wd_fault_q;

  // Reset levels: pulled-up pins inactive high, kick pulled low
  pin_sync #(.RESET_LEVEL(1'b1)) sync_mr (
    .clock  (clock),
    .reset  (reset),
    .enable (clock_enable),
    .pin    (manual_reset_in_n),
    .level  (mr_n_s)
  );
  pin_sync #(.RESET_LEVEL(1'b1)) sync_hold (
    .clock  (clock),
    .reset  (reset),
    .enable (clock_enable),
    .pin    (hold_in_n),
    .level  (hold_n_s)
  );
  pin_sync #(.RESET_LEVEL(1'b0)) sync_kick (
    .clock  (clock),
    .reset  (reset),
    .enable (clock_enable),
    .pin    (watchdog_kick),
    .level  (kick_s)
  );

  // Comparator flags are analog-side, so they get a synchroniser too
  always @(posedge clock) begin
    if (reset) begin
      uv_meta_q <= {`NUM_INPUTS{1'b0}};
      uv_q      <= {`NUM_INPUTS{1'b0}};
      ov_meta_q <= {`NUM_INPUTS{1'b0}};
      ov_q      <= {`NUM_INPUTS{1'b0}};
    end else if (clock_enable) begin
      uv_meta_q <= undervoltage;
      uv_q      <= uv_meta_q;
      ov_meta_q <= overvoltage;
      ov_q      <= ov_meta_q;
    end
  end

  assign uv_s_any = flag_any(uv_q);
  assign ov_s_any = flag_any(ov_q);

  // Glitch filter: low must persist 100ns (20 cycles) to count, well under 1us
  always @(posedge clock) begin
    if (reset) begin
      mr_low_cnt_q <= 8'h00;
      mr_valid_q   <= 1'b0;
    end else if (clock_enable) begin
      if (mr_n_s) begin
        mr_low_cnt_q <= 8'h00;
        mr_valid_q   <= 1'b0;
      end else if (mr_low_cnt_q >= MR_FILTER) begin
        mr_valid_q   <= 1'b1;
      end else begin
        mr_low_cnt_q <= mr_low_cnt_q + 8'h01;
      end
    end
  end

  // Stretch reset 200ms after the last cause clears; new cause restarts
  hold_timer #(.WIDTH(32)) reset_hold (
    .clock  (clock),
    .reset  (reset),
    .enable (clock_enable),
    .cause  (uv_s_any | mr_valid_q),
    .length (RESET_HOLD_CYCLES),
    .active (reset_stretched)
  );

  // Overvoltage stretch of 25us; idle after reset so no false pulse
  hold_timer #(.WIDTH(32), .ACTIVE_AT_RESET(1'b0)) ov_hold (
    .clock  (clock),
    .reset  (reset),
    .enable (clock_enable),
    .cause  (ov_s_any),
    .length (OV_HOLD_CYCLES),
    .active (ov_stretched)
  );

  // Watchdog: edge on synchronised kick restarts the count
  always @(posedge clock) begin
    if (reset) begin
      kick_prev_q  <= 1'b0;
      wd_cnt_q     <= 36'h0;
      wd_initial_q <= 1'b1;
      wd_fault_q   <= 1'b0;
    end else if (clock_enable) begin
      kick_prev_q <= kick_s;
      if (kick_s != kick_prev_q) begin
        wd_cnt_q     <= 36'h0;
        wd_initial_q <= 1'b0;
        wd_fault_q   <= 1'b0;
      end else if (wd_cnt_q >= (wd_initial_q ? WD_INIT_CYCLES : WD_NORM_CYCLES)
                   - 36'h1) begin
        wd_fault_q   <= 1'b1;
      end else begin
        wd_cnt_q     <= wd_cnt_q + 36'h1;
      end
    end
  end

  // Open-drain pins: drive low when asserted, release otherwise
  always @(posedge clock) begin
    if (reset) begin
      reset_out_n        <= 1'b0;
      reset_out_oe       <= 1'b1;
      overvoltage_out_n  <= 1'b0;
      overvoltage_out_oe <= 1'b0;
      watchdog_fault_n   <= 1'b0;
      watchdog_fault_oe  <= 1'b0;
    end else if (clock_enable) begin
      // Hold low freezes reset pin, also over manual reset
      if (hold_n_s) begin
        reset_out_oe <= reset_stretched;
      end
      overvoltage_out_oe <= ov_stretched;
      watchdog_fault_oe  <= wd_fault_q;
    end
  end
endmodule // supply_supervisor_logic

// ===== rtl/supply_supervisor_map.vh
// Constants for the supply supervisor logic
`ifndef SUPPLY_SUPERVISOR_MAP_VH
`define SUPPLY_SUPERVISOR_MAP_VH
`define CLK_PERIOD_PS       64'd5000
`define RESET_HOLD_MS       64'd200
`define OV_HOLD_US          64'd25
`define WD_INIT_MS          64'd102400
`define WD_NORM_MS          64'd1600
`define MR_MIN_NS           64'd1000
`define MR_GLITCH_NS        64'd100
`define KICK_MIN_NS         64'd50
// Cycle counts at a 5ns clock, sized to the registers that hold them
`define RESET_HOLD_CYC      32'd40000000
`define OV_HOLD_CYC         32'd5000
`define WD_INIT_CYC         36'd20480000000
`define WD_NORM_CYC         36'd320000000
`define MR_FILTER_CYC       8'd20
`define NUM_INPUTS          6
`endif

// ===== rtl/pin_sync.v
// Two flip-flop synchroniser with a selectable reset level
module pin_sync #(
  parameter RESET_LEVEL = 1'b0
) (
  input  wire clock,
  input  wire reset,
  input  wire enable,
  input  wire pin,
  output reg  level
);
  reg meta_q;

  always @(posedge clock) begin
    if (reset) begin
      meta_q <= RESET_LEVEL;
      level  <= RESET_LEVEL;
    end else if (enable) begin
      meta_q <= pin;
      level  <= meta_q;
    end
  end
endmodule // pin_sync

// ===== rtl/hold_timer.v
// Restartable down-counter that stretches an active condition
module hold_timer #(
  parameter WIDTH           = 32,
  parameter ACTIVE_AT_RESET = 1'b1
) (
  input  wire             clock,
  input  wire             reset,
  input  wire             enable,
  input  wire             cause,
  input  wire [WIDTH-1:0] length,
  output reg              active
);
  reg [WIDTH-1:0] count_q;

  always @(posedge clock) begin
    if (reset) begin
      count_q <= {WIDTH{1'b0}};
      active  <= ACTIVE_AT_RESET;
    end else if (enable) begin
      if (cause) begin
        count_q <= length;
        active  <= 1'b1;
      end else if (count_q != {WIDTH{1'b0}}) begin
        count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
        active  <= 1'b1;
      end else begin
        active  <= 1'b0;
      end
    end
  end
endmodule // hold_timer

// ===== tb/supply_supervisor_monitor.sv
// Pin-level assertions for the supply supervisor logic
module supply_supervisor_monitor (
  input wire       clock,
  input wire       reset,
  input wire [5:0] undervoltage,
  input wire [5:0] overvoltage,
  input wire       manual_reset_in_n,
  input wire       hold_in_n,
  input wire       watchdog_kick,
  input wire       reset_out_oe,
  input wire       overvoltage_out_oe,
  input wire       watchdog_fault_oe
);
  logic [11:0] rq, oq, wq;
  logic        kq, kd, booted;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Cycles since each cause last stood, measured at the pins
  always_ff @(posedge clock) begin
    kq <= watchdog_kick;
    kd <= !reset && (kd || watchdog_kick != kq);
    // Power-up release of reset is not a stretched release
    booted <= !reset && (booted || !reset_out_oe);
    rq <= (reset || |undervoltage || !manual_reset_in_n) ? 12'h000 : rq + 12'h001;
    oq <= (reset || |overvoltage) ? 12'h000 : oq + 12'h001;
    wq <= (reset || watchdog_kick != kq) ? 12'h000 : wq + 12'h001;
  end
  property p_uv; (|undervoltage && hold_in_n)[*6] |-> reset_out_oe; endproperty
  a_uv: assert property (p_uv) else $error("no reset on undervoltage");
  property p_rh; $fell(reset_out_oe) && booted |-> rq >= 12'h032; endproperty
  a_rh: assert property (p_rh) else $error("reset released early");
  property p_ov; (|overvoltage)[*6] |-> overvoltage_out_oe; endproperty
  a_ov: assert property (p_ov) else $error("no overvoltage output");
  property p_oh; $fell(overvoltage_out_oe) |-> oq >= 12'h014; endproperty
  a_oh: assert property (p_oh) else $error("overvoltage released early");
  property p_or; oq == 12'h01e |-> !overvoltage_out_oe; endproperty
  a_or: assert property (p_or) else $error("overvoltage stuck");
  property p_wd; $rose(watchdog_fault_oe) |-> wq >= (kd ? 12'h064 : 12'h190); endproperty
  a_wd: assert property (p_wd) else $error("watchdog fault early");
  property p_kick; watchdog_kick != kq |-> ##6 !watchdog_fault_oe; endproperty
  a_kick: assert property (p_kick) else $error("kick left fault set");
  property p_hold; !hold_in_n[*6] |-> $stable(reset_out_oe); endproperty
  a_hold: assert property (p_hold) else $error("reset moved in hold");
  cover property ($rose(watchdog_fault_oe));
  cover property ($fell(reset_out_oe));
  cover property ($fell(overvoltage_out_oe));
endmodule // supply_supervisor_monitor
bind supply_supervisor_logic supply_supervisor_monitor i_mon (.*);

// ===== tb/host_model.sv
// Host model that strobes the watchdog kick pin
module host_model (
  input  wire  clock,
  input  wire  kick_en,
  output logic watchdog_kick = 1'b0
);
  logic [5:0] cnt = 6'h00;
  always @(posedge clock) begin
    cnt <= (!kick_en || cnt == 6'h27) ? 6'h00 : cnt + 6'h01;
    // Idle host leaves the pin to its pull-down
    if (!kick_en) watchdog_kick <= 1'b0;
    else if (cnt == 6'h27) watchdog_kick <= ~watchdog_kick;
  end
endmodule // host_model

// ===== tb/supply_supervisor_logic_bench.sv
// Self-checking bench for the supply supervisor logic
module supply_supervisor_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, reset = 1'b1, kick_en = 1'b0, clock_enable = 1'b1;
  logic manual_reset_in_n = 1'b1, hold_in_n = 1'b1;
  logic [5:0] undervoltage = 6'h00, overvoltage = 6'h00;
  logic [7:0] lf = 8'h04;
  logic [2:0] notes[$];
  int miscompares = 0, check_count = 0;
  event probe;
  wire watchdog_kick, reset_out_n, reset_out_oe, overvoltage_out_n;
  wire overvoltage_out_oe, watchdog_fault_n, watchdog_fault_oe;
  supply_supervisor_logic #(32'h32, 32'h14, 36'h190, 36'h64) i_dut (.*);
  host_model i_host (.*);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t pins %b not %b", $time, seen, exp);
    end
  endtask
  task automatic note(input int n, input logic [2:0] exp);
    repeat (n) @(posedge clock);
    notes.push_back(exp);
    -> probe;
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial forever #2.5 clock = ~clock;
  always @(probe) #1 check({reset_out_oe, overvoltage_out_oe, watchdog_fault_oe},
    notes.pop_front());
  initial begin
    #20us;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    note(1, 3'b100);
    note(57, 3'b000);
    note(330, 3'b000);
    note(20, 3'b001);
    kick_en <= 1'b1;
    note(300, 3'b000);
    kick_en <= 1'b0;
    note(90, 3'b000);
    note(25, 3'b001);
    kick_en <= 1'b1;
    note(60, 3'b000);
    $display("watchdog done");
    lf = lfsr(lf);
    undervoltage <= 6'h01 << (lf % 6);
    note(6, 3'b100);
    undervoltage <= 6'h00;
    note(65, 3'b000);
    lf = lfsr(lf);
    overvoltage <= 6'h01 << (lf % 6);
    note(6, 3'b010);
    overvoltage <= 6'h00;
    note(30, 3'b000);
    clock_enable <= 1'b0;
    undervoltage <= 6'h04;
    repeat (4) @(posedge clock);
    undervoltage <= 6'h00;
    note(4, 3'b000);
    clock_enable <= 1'b1;
    note(6, 3'b000);
    $display("supply done");
    // Fault pin is not looped to manual reset here; integrator's choice
    manual_reset_in_n <= 1'b0;
    repeat (10) @(posedge clock);
    manual_reset_in_n <= 1'b1;
    note(30, 3'b000);
    manual_reset_in_n <= 1'b0;
    note(200, 3'b100);
    manual_reset_in_n <= 1'b1;
    note(90, 3'b000);
    hold_in_n <= 1'b0;
    note(6, 3'b000);
    undervoltage <= 6'h20;
    note(10, 3'b000);
    manual_reset_in_n <= 1'b0;
    note(30, 3'b000);
    {hold_in_n, manual_reset_in_n, undervoltage} <= 8'hc0;
    note(100, 3'b000);
    $display("manual reset done");
    @(posedge clock);
    #1 check({reset_out_n, overvoltage_out_n, watchdog_fault_n}, 3'b000);
    summarize();
  end
endmodule // supply_supervisor_logic_bench
